// ### logic/obl_config_loader.sv
`include "obl_consts.svh"

module obl_config_loader
  import obl_pkg::*;
(
  // clock and resets
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      porRst_n,
  // option byte write
  input  wire logic                      optWrEn,
  input  wire logic [15:0]               optWrAddr,
  input  wire obl_byte_t                 optWrData,
  input  wire logic                      optWrDebugLink,
  output logic                           optWrDone,
  output logic                           optWrRefused,
  // option byte read
  input  wire logic                      optRdEn,
  input  wire logic [15:0]               optRdAddr,
  output obl_byte_t                      optRdData,
  output logic                           optRdValid,
  // power modes
  input  wire logic                      haltMode,
  input  wire logic                      activeHaltMode,
  // debug memory access
  input  wire logic                      dbgMemReq,
  output logic                           dbgMemGrant,
  // load status
  output logic                           cfgValid,
  output logic                           bootCheckStrobe,
  output logic [15:0]                    bootSelectWord,
  // memory protection
  output logic                           readoutProtect,
  output logic                           bootAreaEn,
  output logic                           bootVectorsOnly,
  output logic                           bootReadProt,
  output logic                           bootWriteProt,
  output obl_byte_t                      bootLastPage,
  // watchdogs
  output logic                           indepWdgHwStart,
  output logic                           indepWdgHaltStop,
  output logic                           indepWdgFreeze,
  output logic                           winWdgHwStart,
  output logic                           winWdgHaltReset,
  output logic                           winWdgFreeze,
  output logic                           winWdgResetReq,
  // oscillators
  output logic [`OBL_SETTLE_W-1:0]       fastOscSettleCount,
  output logic [`OBL_SETTLE_W-1:0]       slowOscSettleCount,
  // brownout
  output logic                           brownoutEn,
  output logic [2:0]                     brownoutThreshold
);

  function automatic obl_byte_t imgByte(input logic [8*`OBL_NUM_OPT-1:0] img,
                                        input logic [`OBL_IDX_W-1:0]     idx);
    imgByte = img[8*idx +: 8];
  endfunction : imgByte

  function automatic logic [`OBL_SETTLE_W-1:0] settleCycles(input logic [1:0] code);
    unique case (code)
      2'h0:    settleCycles = `OBL_SETTLE_C0;
      2'h1:    settleCycles = `OBL_SETTLE_C1;
      2'h2:    settleCycles = `OBL_SETTLE_C2;
      2'h3:    settleCycles = `OBL_SETTLE_C3;
    endcase
  endfunction : settleCycles

  obl_state_t                  state_q;
  obl_state_t                  state_d;
  logic [`OBL_IDX_W-1:0]       loadIdx_q;
  logic [`OBL_IDX_W-1:0]       loadIdx_d;
  obl_byte_t                   act_q [`OBL_NUM_OPT];
  logic [`OBL_NUM_OPT-1:0]     actLoad;
  logic                        haltPrev_q;
  logic [8*`OBL_NUM_OPT-1:0]   storeImg;
  logic                        wrAccept;
  logic                        rdHit;
  logic [`OBL_IDX_W-1:0]       rdIdx;
  wire                         running;
  wire                         storeWrEn;
  wire                         protOpen;
  wire                         anyHalt;
  wire                         haltEntry;
  obl_byte_t                   wdogByte;
  obl_byte_t                   oscByte;
  obl_byte_t                   brownByte;
  logic                        decAreaEn;
  logic                        decVectOnly;
  logic                        decReadProt;
  logic                        decWriteProt;
  obl_byte_t                   decLastPage;

  assign running   = (state_q == OBL_RUN);
  // writes are refused until the load walk is finished
  assign storeWrEn = optWrEn && running;
  assign protOpen  = (act_q[`OBL_IDX_PROT] == `OBL_PROT_OPEN);
  assign anyHalt   = haltMode || activeHaltMode;
  assign haltEntry = haltMode && !haltPrev_q;
  assign wdogByte  = act_q[`OBL_IDX_WDOG];
  assign oscByte   = act_q[`OBL_IDX_OSC];
  assign brownByte = act_q[`OBL_IDX_BROWN];

  obl_option_store uStore (
    .clk         (clk),
    .porRst_n    (porRst_n),
    .wrEn        (storeWrEn),
    .wrAddr      (optWrAddr),
    .wrData      (optWrData),
    .wrDebugLink (optWrDebugLink),
    .wrAccept    (wrAccept),
    .rdAddr      (optRdAddr),
    .rdHit       (rdHit),
    .rdIdx       (rdIdx),
    .image       (storeImg)
  );

  obl_boot_area_decode uBootArea (
    .sizeCode    (act_q[`OBL_IDX_BAREA]),
    .areaEn      (decAreaEn),
    .vectorsOnly (decVectOnly),
    .readProt    (decReadProt),
    .writeProt   (decWriteProt),
    .lastPage    (decLastPage)
  );

  // load walk, one slot per cycle after reset
  always_comb
  begin
    state_d   = state_q;
    loadIdx_d = loadIdx_q;
    unique case (state_q)
      OBL_LOAD:
      begin
        loadIdx_d = loadIdx_q + 1'b1;
        if (loadIdx_q == `OBL_IDX_LAST)
          state_d = OBL_RUN;
      end
      OBL_RUN:
        loadIdx_d = loadIdx_q;
      default:
        state_d = OBL_LOAD;
    endcase
  end

  // protection and boot size only refresh on the reset walk
  always_comb
  begin
    for (int i = 0; i < `OBL_NUM_OPT; i++)
      actLoad[i] = (state_q == OBL_LOAD) ? (int'(loadIdx_q) == i)
                 : (i != int'(`OBL_IDX_PROT)) && (i != int'(`OBL_IDX_BAREA));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q    <= OBL_LOAD;
      loadIdx_q  <= '0;
      haltPrev_q <= 1'b0;
      for (int i = 0; i < `OBL_NUM_OPT; i++)
        act_q[i] <= (i == int'(`OBL_IDX_BROWN)) ? `OBL_RST_BROWN : `OBL_RST_ZERO;
    end
    else
    begin
      state_q    <= state_d;
      loadIdx_q  <= loadIdx_d;
      haltPrev_q <= haltMode;
      for (int i = 0; i < `OBL_NUM_OPT; i++)
        if (actLoad[i])
          act_q[i] <= imgByte(storeImg, `OBL_IDX_W'(i));
    end
  end

  // bus answers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      optWrDone    <= 1'b0;
      optWrRefused <= 1'b0;
      optRdValid   <= 1'b0;
      optRdData    <= `OBL_RST_ZERO;
      dbgMemGrant  <= 1'b0;
    end
    else
    begin
      optWrDone    <= wrAccept;
      optWrRefused <= optWrEn && !wrAccept;
      optRdValid   <= optRdEn;
      optRdData    <= (optRdEn && rdHit) ? imgByte(storeImg, rdIdx) : `OBL_RST_ZERO;
      dbgMemGrant  <= dbgMemReq && running && protOpen;
    end
  end

  // settings handed to the consuming units
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfgValid           <= 1'b0;
      bootCheckStrobe    <= 1'b0;
      bootSelectWord     <= '0;
      readoutProtect     <= 1'b1;
      bootAreaEn         <= 1'b0;
      bootVectorsOnly    <= 1'b0;
      bootReadProt       <= 1'b0;
      bootWriteProt      <= 1'b0;
      bootLastPage       <= `OBL_PAGE_ZERO;
      indepWdgHwStart    <= 1'b0;
      indepWdgHaltStop   <= 1'b0;
      indepWdgFreeze     <= 1'b0;
      winWdgHwStart      <= 1'b0;
      winWdgHaltReset    <= 1'b0;
      winWdgFreeze       <= 1'b0;
      winWdgResetReq     <= 1'b0;
      fastOscSettleCount <= `OBL_SETTLE_C0;
      slowOscSettleCount <= `OBL_SETTLE_C0;
      brownoutEn         <= 1'b1;
      brownoutThreshold  <= '0;
    end
    else
    begin
      cfgValid           <= running;
      bootCheckStrobe    <= running && !cfgValid;
      bootSelectWord     <= {act_q[`OBL_IDX_BSEL_H], act_q[`OBL_IDX_BSEL_L]};
      readoutProtect     <= !protOpen;
      bootAreaEn         <= decAreaEn;
      bootVectorsOnly    <= decVectOnly;
      bootReadProt       <= decReadProt;
      bootWriteProt      <= decWriteProt;
      bootLastPage       <= decLastPage;
      indepWdgHwStart    <= wdogByte[`OBL_BIT_IWD_HW];
      indepWdgHaltStop   <= wdogByte[`OBL_BIT_IWD_HALT];
      indepWdgFreeze     <= anyHalt && wdogByte[`OBL_BIT_IWD_HALT];
      winWdgHwStart      <= wdogByte[`OBL_BIT_WWD_HW];
      winWdgHaltReset    <= wdogByte[`OBL_BIT_WWD_HALT];
      winWdgFreeze       <= haltMode && !wdogByte[`OBL_BIT_WWD_HALT];
      winWdgResetReq     <= haltEntry && wdogByte[`OBL_BIT_WWD_HALT];
      fastOscSettleCount <= settleCycles(oscByte[`OBL_FAST_HI:`OBL_FAST_LO]);
      slowOscSettleCount <= settleCycles(oscByte[`OBL_SLOW_HI:`OBL_SLOW_LO]);
      brownoutEn         <= brownByte[`OBL_BIT_BROWN_EN];
      brownoutThreshold  <= brownByte[`OBL_BROWN_TH_HI:`OBL_BROWN_TH_LO];
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  wire protAddr = (optWrAddr == `OBL_ADDR_PROT) || (optWrAddr == `OBL_ADDR_BAREA);

  sequence sHeldLoading;
    !cfgValid [*8] ##1 !cfgValid;
  endsequence

  sequence sReleased;
    cfgValid && bootCheckStrobe ##1 cfgValid && !bootCheckStrobe;
  endsequence

  a_load_release: assert property ($rose(rst_n) |-> sHeldLoading ##1 sReleased)
    else $error("consumers not released nine cycles after reset");

  a_write_in_load: assert property (optWrEn && !running |=> optWrRefused && !optWrDone)
    else $error("write taken during load walk");

  a_prot_open: assert property (running && act_q[`OBL_IDX_PROT] == `OBL_PROT_OPEN
                                ##1 dbgMemReq |=> dbgMemGrant && !readoutProtect)
    else $error("debug access refused with protection open");

  a_prot_closed: assert property (act_q[`OBL_IDX_PROT] != `OBL_PROT_OPEN |=>
                                  readoutProtect && !dbgMemGrant)
    else $error("protection dropped without open code");

  a_app_locked: assert property (optWrEn && !optWrDebugLink && protAddr |=>
                                 optWrRefused && $stable(act_q[`OBL_IDX_PROT]))
    else $error("application write to locked byte taken");

  a_link_write: assert property (running && optWrEn && optWrDebugLink && optWrAddr == `OBL_ADDR_WDOG
                                 |=> optWrDone ##1 wdogByte == ($past(optWrData, 2) & `OBL_MASK_LOW4))
    else $error("debug link write not stored and applied");

  a_area_two: assert property (act_q[`OBL_IDX_BAREA] == `OBL_BAREA_TWO |=>
                               bootReadProt && bootWriteProt && bootLastPage == `OBL_PAGE_ONE)
    else $error("boot area code two decoded wrong");

  a_area_cap: assert property (act_q[`OBL_IDX_BAREA] >= `OBL_BAREA_CAP |=>
                               bootWriteProt && !bootReadProt && bootLastPage == `OBL_BAREA_MAXPG)
    else $error("boot area cap not page 254");

  a_iwd_start: assert property ($rose(wdogByte[`OBL_BIT_IWD_HW]) |=> $rose(indepWdgHwStart))
    else $error("independent watchdog start not following");

  a_iwd_freeze: assert property (activeHaltMode && wdogByte[`OBL_BIT_IWD_HALT] |=> indepWdgFreeze)
    else $error("independent watchdog runs in halt with stop set");

  a_wwd_start: assert property ($fell(wdogByte[`OBL_BIT_WWD_HW]) |=> !winWdgHwStart)
    else $error("window watchdog start not following");

  a_wwd_reset: assert property ($rose(haltMode) && wdogByte[`OBL_BIT_WWD_HALT] |=>
                                winWdgResetReq && !winWdgFreeze ##1 !winWdgResetReq)
    else $error("window watchdog halt reset not a single pulse");

  a_fast_settle: assert property (oscByte[`OBL_FAST_HI:`OBL_FAST_LO] == 2'h3 |=>
                                  fastOscSettleCount == 13'h1000)
    else $error("fast oscillator settle count wrong");

  a_slow_settle: assert property (oscByte[`OBL_SLOW_HI:`OBL_SLOW_LO] == 2'h1 |=>
                                  slowOscSettleCount == 13'h0010)
    else $error("slow oscillator settle count wrong");

  a_brown_fields: assert property (brownByte == 8'h0B |=> brownoutEn && brownoutThreshold == 3'h5)
    else $error("brownout fields misplaced");

  a_boot_word: assert property (bootCheckStrobe |-> bootSelectWord ==
                                {act_q[`OBL_IDX_BSEL_H], act_q[`OBL_IDX_BSEL_L]})
    else $error("boot select word not ready at check strobe");

endmodule : obl_config_loader

// ### logic/obl_consts.svh
`ifndef OBL_CONSTS_SVH
`define OBL_CONSTS_SVH

// option byte addresses
`define OBL_ADDR_PROT   16'h4800
`define OBL_ADDR_BAREA  16'h4802
`define OBL_ADDR_RSVD   16'h4807
`define OBL_ADDR_WDOG   16'h4808
`define OBL_ADDR_OSC    16'h4809
`define OBL_ADDR_BROWN  16'h480A
`define OBL_ADDR_BSEL_H 16'h480B
`define OBL_ADDR_BSEL_L 16'h480C

// storage slots
`define OBL_NUM_OPT     8
`define OBL_IDX_W       3
`define OBL_IDX_PROT    3'h0
`define OBL_IDX_BAREA   3'h1
`define OBL_IDX_RSVD    3'h2
`define OBL_IDX_WDOG    3'h3
`define OBL_IDX_OSC     3'h4
`define OBL_IDX_BROWN   3'h5
`define OBL_IDX_BSEL_H  3'h6
`define OBL_IDX_BSEL_L  3'h7
`define OBL_IDX_LAST    3'h7

// factory values and write masks
`define OBL_RST_ZERO    8'h00
`define OBL_RST_BROWN   8'h01
`define OBL_MASK_FULL   8'hFF
`define OBL_MASK_LOW4   8'h0F
`define OBL_MASK_NONE   8'h00

// readout protection
`define OBL_PROT_OPEN   8'hAA

// boot area size codes
`define OBL_BAREA_NONE  8'h00
`define OBL_BAREA_VECT  8'h01
`define OBL_BAREA_TWO   8'h02
`define OBL_BAREA_CAP   8'hFE
`define OBL_BAREA_MAXPG 8'hFE
`define OBL_PAGE_ONE    8'h01
`define OBL_PAGE_ZERO   8'h00

// field positions
`define OBL_BIT_IWD_HW    0
`define OBL_BIT_IWD_HALT  1
`define OBL_BIT_WWD_HW    2
`define OBL_BIT_WWD_HALT  3
`define OBL_FAST_HI       1
`define OBL_FAST_LO       0
`define OBL_SLOW_HI       3
`define OBL_SLOW_LO       2
`define OBL_BIT_BROWN_EN  0
`define OBL_BROWN_TH_HI   3
`define OBL_BROWN_TH_LO   1

// oscillator settle counts
`define OBL_SETTLE_W      13
`define OBL_SETTLE_C0     13'h0001
`define OBL_SETTLE_C1     13'h0010
`define OBL_SETTLE_C2     13'h0200
`define OBL_SETTLE_C3     13'h1000

`endif

// ### logic/obl_pkg.sv
package obl_pkg;

  typedef logic [7:0] obl_byte_t;

  typedef enum logic [1:0] {
    OBL_LOAD = 2'b01,
    OBL_RUN  = 2'b10
  } obl_state_t;

endpackage : obl_pkg

// ### logic/obl_option_store.sv
`include "obl_consts.svh"

module obl_option_store
  import obl_pkg::*;
(
  // clock and storage reset
  input  wire logic                       clk,
  input  wire logic                       porRst_n,
  // write request
  input  wire logic                       wrEn,
  input  wire logic [15:0]                wrAddr,
  input  wire obl_byte_t                  wrData,
  input  wire logic                       wrDebugLink,
  output logic                            wrAccept,
  // read lookup
  input  wire logic [15:0]                rdAddr,
  output logic                            rdHit,
  output logic [`OBL_IDX_W-1:0]           rdIdx,
  // stored image
  output logic [8*`OBL_NUM_OPT-1:0]       image
);

  obl_byte_t mem_q [`OBL_NUM_OPT];

  function automatic logic [`OBL_IDX_W:0] addrDecode(input logic [15:0] a);
    unique case (a)
      `OBL_ADDR_PROT:   addrDecode = {1'b1, `OBL_IDX_PROT};
      `OBL_ADDR_BAREA:  addrDecode = {1'b1, `OBL_IDX_BAREA};
      `OBL_ADDR_RSVD:   addrDecode = {1'b1, `OBL_IDX_RSVD};
      `OBL_ADDR_WDOG:   addrDecode = {1'b1, `OBL_IDX_WDOG};
      `OBL_ADDR_OSC:    addrDecode = {1'b1, `OBL_IDX_OSC};
      `OBL_ADDR_BROWN:  addrDecode = {1'b1, `OBL_IDX_BROWN};
      `OBL_ADDR_BSEL_H: addrDecode = {1'b1, `OBL_IDX_BSEL_H};
      `OBL_ADDR_BSEL_L: addrDecode = {1'b1, `OBL_IDX_BSEL_L};
      default:          addrDecode = '0;
    endcase
  endfunction : addrDecode

  logic                  wrHit;
  logic [`OBL_IDX_W-1:0] wrIdx;
  wire                   wrLocked;
  obl_byte_t             wrMask;

  assign {wrHit, wrIdx} = addrDecode(wrAddr);
  assign {rdHit, rdIdx} = addrDecode(rdAddr);

  // protection and boot area only from the debug link
  assign wrLocked = (wrIdx == `OBL_IDX_PROT) || (wrIdx == `OBL_IDX_BAREA);
  assign wrAccept = wrEn && wrHit && (wrDebugLink || !wrLocked);

  // reserved slot and reserved upper bits hold zero
  assign wrMask = (wrIdx == `OBL_IDX_RSVD) ? `OBL_MASK_NONE :
                  (wrIdx == `OBL_IDX_WDOG || wrIdx == `OBL_IDX_OSC || wrIdx == `OBL_IDX_BROWN)
                  ? `OBL_MASK_LOW4 : `OBL_MASK_FULL;

  always_ff @(posedge clk)
  begin
    if (!porRst_n)
    begin
      for (int i = 0; i < `OBL_NUM_OPT; i++)
        mem_q[i] <= (i == int'(`OBL_IDX_BROWN)) ? `OBL_RST_BROWN : `OBL_RST_ZERO;
    end
    else if (wrAccept)
      mem_q[wrIdx] <= wrData & wrMask;
  end

  for (genvar g = 0; g < `OBL_NUM_OPT; g++)
  begin : gImg
    assign image[8*g +: 8] = mem_q[g];
  end

endmodule : obl_option_store

// ### logic/obl_boot_area_decode.sv
`include "obl_consts.svh"

module obl_boot_area_decode
  import obl_pkg::*;
(
  // size code
  input  wire obl_byte_t  sizeCode,
  // decoded area
  output logic            areaEn,
  output logic            vectorsOnly,
  output logic            readProt,
  output logic            writeProt,
  output obl_byte_t       lastPage
);

  wire isNone = (sizeCode == `OBL_BAREA_NONE);
  wire isVect = (sizeCode == `OBL_BAREA_VECT);
  wire isTwo  = (sizeCode == `OBL_BAREA_TWO);
  wire isCap  = (sizeCode >= `OBL_BAREA_CAP);

  assign areaEn      = !isNone;
  assign vectorsOnly = isVect || isTwo;
  assign readProt    = isTwo;
  assign writeProt   = !isNone && !isVect;
  // pages 0 to code-1; codes 254 and up give page 254
  assign lastPage    = isCap ? `OBL_BAREA_MAXPG :
                       (isNone || isVect) ? `OBL_PAGE_ZERO : sizeCode - `OBL_PAGE_ONE;

endmodule : obl_boot_area_decode

// ### verification/obl_prog_model.sv
module obl_prog_model
  import obl_pkg::*;
(
  // clock
  input  wire logic   clk,
  // option byte write
  output logic        wrEn,
  output logic [15:0] wrAddr,
  output obl_byte_t   wrData,
  output logic        wrLink,
  input  wire logic   wrDone,
  input  wire logic   wrRefused,
  // debug memory access
  output logic        memReq,
  input  wire logic   memGrant
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    wrEn = 1'b0;
    wrAddr = 16'h0000;
    wrData = 8'h00;
    wrLink = 1'b0;
    memReq = 1'b0;
  end

  // one write; released lines show the inverse
  task put(input logic [15:0] a, input obl_byte_t d, input logic viaLink, output logic [1:0] ans);
    @(posedge clk);
    wrEn <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    wrLink <= viaLink;
    @(posedge clk);
    wrEn <= 1'b0;
    wrAddr <= ~a;
    wrData <= ~d;
    wrLink <= ~viaLink;
    #1;
    ans = {wrDone, wrRefused};
  endtask : put

  // debug memory request level
  task access(input logic r, output logic g);
    @(posedge clk);
    memReq <= r;
    @(posedge clk);
    #1;
    g = memGrant;
  endtask : access
endmodule : obl_prog_model

// ### verification/testbench.sv
`include "obl_consts.svh"

module testbench
  import obl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] SETTLE [4] = '{16'h0001, 16'h0010, 16'h0200, 16'h1000};
  localparam logic [7:0]  BCODE [7]  = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFD, 8'hFE, 8'hFF};
  localparam logic [15:0] BEXP [7]   = '{16'h0000, 16'h0400, 16'h0701, 16'h0502, 16'h05FC, 16'h05FE, 16'h05FE};
  localparam logic [15:0] REGA [8]   = '{16'h4800, 16'h4802, 16'h4807, 16'h4808, 16'h4809, 16'h480A, 16'h480B,
                                         16'h480C};

  logic                          clk, rst_n, porRst_n, optWrEn, optWrDebugLink, optWrDone, optWrRefused;
  logic [15:0]                   optWrAddr, optRdAddr, bootSelectWord;
  obl_byte_t                     optWrData, optRdData, bootLastPage;
  logic                          optRdEn, optRdValid, haltMode, activeHaltMode, dbgMemReq, dbgMemGrant;
  logic                          cfgValid, bootCheckStrobe, readoutProtect, bootAreaEn, bootVectorsOnly;
  logic                          bootReadProt, bootWriteProt, indepWdgHwStart, indepWdgHaltStop, indepWdgFreeze;
  logic                          winWdgHwStart, winWdgHaltReset, winWdgFreeze, winWdgResetReq, brownoutEn, g;
  logic [`OBL_SETTLE_W-1:0]      fastOscSettleCount, slowOscSettleCount;
  logic [2:0]                    brownoutThreshold;
  int                            badCount = 0;
  int                            nTests = 0;

  obl_config_loader obl_config_loader_inst (.clk, .rst_n, .porRst_n, .optWrEn, .optWrAddr, .optWrData,
    .optWrDebugLink, .optWrDone, .optWrRefused, .optRdEn, .optRdAddr, .optRdData, .optRdValid, .haltMode,
    .activeHaltMode, .dbgMemReq, .dbgMemGrant, .cfgValid, .bootCheckStrobe, .bootSelectWord, .readoutProtect,
    .bootAreaEn, .bootVectorsOnly, .bootReadProt, .bootWriteProt, .bootLastPage, .indepWdgHwStart,
    .indepWdgHaltStop, .indepWdgFreeze, .winWdgHwStart, .winWdgHaltReset, .winWdgFreeze, .winWdgResetReq,
    .fastOscSettleCount, .slowOscSettleCount, .brownoutEn, .brownoutThreshold);

  obl_prog_model obl_prog_model_inst (.clk, .wrEn(optWrEn), .wrAddr(optWrAddr), .wrData(optWrData),
    .wrLink(optWrDebugLink), .wrDone(optWrDone), .wrRefused(optWrRefused), .memReq(dbgMemReq),
    .memGrant(dbgMemGrant));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task giveVerdict;
    if (badCount == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : giveVerdict

  task chk(input string what, input logic [15:0] e, input logic [15:0] s);
    nTests++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      badCount++;
    end
  endtask : chk

  task wr(input logic [15:0] a, input obl_byte_t d, input logic l, input logic [1:0] e);
    logic [1:0] r;
    obl_prog_model_inst.put(a, d, l, r);
    chk("write answer", {14'h0000, e}, {14'h0000, r});
  endtask : wr

  task rd(input logic [15:0] a, input obl_byte_t e);
    @(posedge clk);
    optRdEn <= 1'b1;
    optRdAddr <= a;
    @(posedge clk);
    optRdEn <= 1'b0;
    optRdAddr <= ~a;
    #1;
    chk("read", {7'h00, 1'b1, e}, {7'h00, optRdValid, optRdData});
  endtask : rd

  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task mode(input logic h, input logic a);
    @(posedge clk);
    haltMode <= h;
    activeHaltMode <= a;
    @(posedge clk);
    #1;
  endtask : mode

  task sysReset(input logic por);
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    porRst_n <= ~por;
    @(posedge clk);
    #1;
    chk("reset outputs", 16'h000E, {fastOscSettleCount, readoutProtect, brownoutEn, cfgValid});
    @(posedge clk);
    rst_n <= 1'b1;
    porRst_n <= 1'b1;
    n = 0;
    while (cfgValid !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("load edges", 16'h0009, 16'(n));
    chk("boot check", 16'h0001, {15'h0000, bootCheckStrobe});
    @(posedge clk);
    #1;
    chk("boot check end", 16'h0000, {15'h0000, bootCheckStrobe});
  endtask : sysReset

  task tProt;
    wr(`OBL_ADDR_PROT, 8'hAA, 1'b0, 2'b01);
    wr(`OBL_ADDR_PROT, 8'hAA, 1'b1, 2'b10);
    settle();
    chk("prot before reset", 16'h0001, {15'h0000, readoutProtect});
    sysReset(1'b0);
    chk("prot open", 16'h0000, {15'h0000, readoutProtect});
    obl_prog_model_inst.access(1'b1, g);
    chk("grant open", 16'h0001, {15'h0000, g});
    wr(`OBL_ADDR_PROT, 8'hAB, 1'b1, 2'b10);
    sysReset(1'b0);
    settle();
    chk("prot closed", 16'h0003, {14'h0000, readoutProtect, ~dbgMemGrant});
    obl_prog_model_inst.access(1'b0, g);
  endtask : tProt

  task tBoot;
    wr(`OBL_ADDR_BAREA, 8'h02, 1'b0, 2'b01);
    foreach (BCODE[i])
    begin
      wr(`OBL_ADDR_BAREA, BCODE[i], 1'b1, 2'b10);
      sysReset(1'b0);
      chk("boot area", BEXP[i], {5'h00, bootAreaEn, bootReadProt, bootWriteProt, bootLastPage});
      chk("vectors only", {15'h0000, (i == 1) || (i == 2)}, {15'h0000, bootVectorsOnly});
    end
  endtask : tBoot

  task tWdg;
    for (int i = 0; i < 4; i++)
    begin
      wr(`OBL_ADDR_WDOG, 8'hF0 | 8'(8'h01 << i), 1'b0, 2'b10);
      settle();
      chk("wdog bits", 16'h0001 << i, {12'h000, winWdgHaltReset, winWdgHwStart, indepWdgHaltStop,
        indepWdgHwStart});
      rd(`OBL_ADDR_WDOG, 8'(8'h01 << i));
    end
    mode(1'b1, 1'b0);
    chk("halt reset", 16'h0004, {13'h0000, winWdgResetReq, winWdgFreeze, indepWdgFreeze});
    @(posedge clk);
    #1;
    chk("halt reset end", 16'h0000, {13'h0000, winWdgResetReq, winWdgFreeze, indepWdgFreeze});
    mode(1'b0, 1'b0);
    wr(`OBL_ADDR_WDOG, 8'h02, 1'b1, 2'b10);
    settle();
    mode(1'b0, 1'b1);
    chk("active halt", 16'h0001, {13'h0000, winWdgResetReq, winWdgFreeze, indepWdgFreeze});
    mode(1'b1, 1'b0);
    chk("halt stop", 16'h0003, {13'h0000, winWdgResetReq, winWdgFreeze, indepWdgFreeze});
    mode(1'b0, 1'b0);
    wr(`OBL_ADDR_WDOG, 8'h00, 1'b0, 2'b10);
    settle();
    mode(1'b1, 1'b0);
    chk("halt run", 16'h0002, {13'h0000, winWdgResetReq, winWdgFreeze, indepWdgFreeze});
    mode(1'b0, 1'b0);
  endtask : tWdg

  task tOsc;
    fork
      sysReset(1'b0);
      begin
        repeat (3) @(posedge clk);
        wr(`OBL_ADDR_OSC, 8'h0F, 1'b0, 2'b01);
      end
    join
    rd(`OBL_ADDR_OSC, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(`OBL_ADDR_OSC, {4'hF, 2'(3 - c), 2'(c)}, 1'b0, 2'b10);
      settle();
      chk("fast settle", SETTLE[c], {3'h0, fastOscSettleCount});
      chk("slow settle", SETTLE[3 - c], {3'h0, slowOscSettleCount});
    end
  endtask : tOsc

  task tBrown;
    wr(`OBL_ADDR_BROWN, 8'hFE, 1'b0, 2'b10);
    settle();
    chk("brownout", 16'h000E, {12'h000, brownoutThreshold, brownoutEn});
    rd(`OBL_ADDR_BROWN, 8'h0E);
    wr(`OBL_ADDR_BROWN, 8'h0B, 1'b1, 2'b10);
    settle();
    chk("brownout", 16'h000B, {12'h000, brownoutThreshold, brownoutEn});
    wr(`OBL_ADDR_RSVD, 8'hFF, 1'b0, 2'b10);
    rd(`OBL_ADDR_RSVD, 8'h00);
    wr(16'h4801, 8'h5A, 1'b1, 2'b01);
    rd(16'h4801, 8'h00);
  endtask : tBrown

  task tWord;
    wr(`OBL_ADDR_BSEL_H, 8'h12, 1'b1, 2'b10);
    wr(`OBL_ADDR_BSEL_L, 8'h34, 1'b0, 2'b10);
    sysReset(1'b0);
    chk("boot word", 16'h1234, bootSelectWord);
    sysReset(1'b1);
    foreach (REGA[i])
      rd(REGA[i], (REGA[i] == 16'h480A) ? 8'h01 : 8'h00);
    chk("boot word factory", 16'h0001, {bootSelectWord[14:0], brownoutEn});
  endtask : tWord

  initial
  begin
    rst_n = 1'b0;
    porRst_n = 1'b0;
    optRdEn = 1'b0;
    optRdAddr = 16'h0000;
    haltMode = 1'b0;
    activeHaltMode = 1'b0;
    sysReset(1'b1);
    tProt();
    tBoot();
    tWdg();
    tOsc();
    tBrown();
    tWord();
    giveVerdict();
  end

  initial
  begin
    #(25 * 5000);
    badCount++;
    giveVerdict();
  end
endmodule : testbench
